// [rtl/adc_scan_defines.vh]
`ifndef ADC_SCAN_DEFINES_VH
`define ADC_SCAN_DEFINES_VH

// register byte addresses
`define ADDR_SCAN_MASK      4'h0
`define ADDR_CLK_CTRL       4'h4
`define ADDR_SCAN_STATUS    4'h8
`define ADDR_SCAN_CTRL      4'hC

// scan mask layout
`define MASK_WRITABLE       16'h9FFF
`define MASK_RESET          16'h0000
`define BANDGAP_BIT         15
`define NUM_EXT_CH          13
`define NUM_SLOTS           16
`define CH_W                4

// clock divider
`define DIV_W               8
`define DIV_RESET           8'h00
`define TCY_OSC_PERIODS     2
`define TCY_LAST            2'h1

// axi responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// [rtl/adc_clock_divider.v]
`include "adc_scan_defines.vh"
`default_nettype none

// instruction cycle from oscillator, then conversion clock from instruction cycle
module adc_clock_divider (
  // clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  // divider setting
  input  wire [`DIV_W-1:0] conv_clock_divider,
  // outputs
  output reg               instr_tick,
  output reg               conv_tick
);

  reg [1:0]        osc_count;
  reg [`DIV_W-1:0] cy_count;

  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_count  <= 2'h0;
      cy_count   <= 8'h00;
      instr_tick <= 1'b0;
      conv_tick  <= 1'b0;
    end else begin
      conv_tick <= 1'b0;
      // one instruction cycle per two oscillator periods
      if (osc_count == `TCY_LAST) begin
        osc_count  <= 2'h0;
        instr_tick <= 1'b1;
      end else begin
        osc_count  <= osc_count + 2'h1;
        instr_tick <= 1'b0;
      end
      // conversion period = instruction cycle * (divider + 1)
      if (osc_count == `TCY_LAST) begin
        if (cy_count >= conv_clock_divider) begin
          cy_count  <= 8'h00;
          conv_tick <= 1'b1;
        end else begin
          cy_count <= cy_count + 8'h01;
        end
      end
    end
  end

endmodule

`default_nettype wire

// [rtl/adc_scan_select_clock.v]
`include "adc_scan_defines.vh"
`default_nettype none

module adc_scan_select_clock (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // converter side
  output reg  [15:0] scan_enable,
  output wire        conv_clock_tick,
  output reg  [3:0]  scan_channel,
  output reg         scan_active
);

  reg  [15:0]        scan_channel_mask;
  reg  [`DIV_W-1:0]  conv_clock_divider;
  reg                scan_run;
  reg                aw_held;
  reg                w_held;
  reg  [3:0]         aw_addr;
  reg  [31:0]        w_data;
  reg  [3:0]         w_strb;
  wire               do_write;
  reg  [15:0]        next_mask;
  reg  [3:0]         next_channel;
  reg                found;
  integer            i;
  reg  [4:0]         idx;

  adc_clock_divider u_div (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .conv_clock_divider (conv_clock_divider),
    .instr_tick         (),
    .conv_tick          (conv_clock_tick)
  );

  // write channel capture, either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
    end
  end

  // byte-lane merge, unused bits forced to zero
  always @* begin
    next_mask = scan_channel_mask;
    if (w_strb[0]) next_mask[7:0] = w_data[7:0];
    if (w_strb[1]) next_mask[15:8] = w_data[15:8];
    next_mask = next_mask & `MASK_WRITABLE;
  end

  // register writes and response
  always @(posedge aclk) begin
    if (!aresetn) begin
      scan_channel_mask  <= `MASK_RESET;
      conv_clock_divider <= `DIV_RESET;
      scan_run           <= 1'b0;
      s_axi_bvalid       <= 1'b0;
      s_axi_bresp        <= `RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        case (aw_addr)
          `ADDR_SCAN_MASK: scan_channel_mask <= next_mask;
          `ADDR_CLK_CTRL: begin
            if (w_strb[0]) conv_clock_divider <= w_data[`DIV_W-1:0];
          end
          `ADDR_SCAN_STATUS: ;
          `ADDR_SCAN_CTRL: begin
            if (w_strb[0]) scan_run <= w_data[0];
          end
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
    end
  end

  // read channel
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
          `ADDR_SCAN_MASK:   s_axi_rdata <= {16'h0000, scan_channel_mask};
          `ADDR_CLK_CTRL:    s_axi_rdata <= {24'h000000, conv_clock_divider};
          `ADDR_SCAN_STATUS: s_axi_rdata <= {27'h0000000, scan_active, scan_channel};
          `ADDR_SCAN_CTRL:   s_axi_rdata <= {31'h00000000, scan_run};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // next enabled channel above current, wrapping to lowest
  always @* begin
    next_channel = scan_channel;
    found        = 1'b0;
    idx          = 5'h00;
    for (i = 1; i <= `NUM_SLOTS; i = i + 1) begin
      idx = {1'b0, scan_channel} + i[4:0];
      if (!found && scan_channel_mask[idx[3:0]]) begin
        found        = 1'b1;
        next_channel = idx[3:0];
      end
    end
  end

  // scan sequencer, one channel per conversion clock
  always @(posedge aclk) begin
    if (!aresetn) begin
      scan_channel <= 4'h0;
      scan_active  <= 1'b0;
      scan_enable  <= 16'h0000;
    end else begin
      scan_enable <= scan_channel_mask;
      if (!scan_run || scan_channel_mask == 16'h0000) begin
        scan_active  <= 1'b0;
        scan_channel <= 4'hF;
      end else if (conv_clock_tick) begin
        scan_active  <= 1'b1;
        scan_channel <= next_channel;
      end
    end
  end

endmodule

`default_nettype wire

// [testbench/adc_scan_select_clock_properties.sv]
`default_nettype none
module adc_scan_select_clock_properties (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // converter side
  input wire logic [15:0] scan_enable,
  input wire logic        conv_clock_tick,
  input wire logic [3:0]  scan_channel,
  input wire logic        scan_active
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] gap;
  logic       seen;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // cycles since the last conversion tick
  always @(posedge aclk) begin
    if (!aresetn) begin
      gap <= 10'h000;
      seen <= 1'b0;
    end else begin
      gap <= conv_clock_tick ? 10'h001 : gap + 10'h001;
      seen <= seen | conv_clock_tick;
    end
  end
  a_bandgap_slot: assert property (scan_active && scan_channel == 4'hF |-> scan_enable[15])
    else $error("band gap converted while not enabled");
  a_unused_zero: assert property (scan_enable[14:13] == 2'b00)
    else $error("unused mask bits set");
  a_channel_slot: assert property (scan_active && scan_channel != 4'hF
    |-> scan_enable[scan_channel])
    else $error("disabled channel converted");
  a_tick_single: assert property (conv_clock_tick |=> !conv_clock_tick)
    else $error("conversion tick wider than one cycle");
  a_period_even: assert property (seen && conv_clock_tick
    |-> gap[0] == 1'b0 && gap >= 10'h002)
    else $error("conversion tick period wrong");
  a_step_on_tick: assert property ($changed(scan_channel) && $past(scan_active) && scan_active
    |-> $past(conv_clock_tick))
    else $error("channel stepped without tick");
  cover property (scan_active && scan_channel == 4'hF);
  cover property (seen && conv_clock_tick);
  cover property ($rose(scan_active));
endmodule
bind adc_scan_select_clock adc_scan_select_clock_properties u_props (.aclk(aclk),
  .aresetn(aresetn), .scan_enable(scan_enable), .conv_clock_tick(conv_clock_tick),
  .scan_channel(scan_channel), .scan_active(scan_active));
`default_nettype wire

// [testbench/adc_scan_select_clock_tb.sv]
`include "adc_scan_defines.vh"
`default_nettype none
module adc_scan_select_clock_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0;
  logic [3:0]  awa = 4'h0, ara = 4'h0, ch;
  logic [31:0] wd = 32'h0, rd;
  logic [1:0]  rs;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [15:0] en;
  wire  [3:0]  chan;
  wire         awr, wr_rdy, bv, arr, rv, tick, act;
  int          num_errors = 0, check_count = 0, n;
  logic [3:0]  sq [$];
  adc_scan_select_clock u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .scan_enable(en), .conv_clock_tick(tick), .scan_channel(chan), .scan_active(act));
  always #10 aclk = ~aclk;
  task automatic report_and_stop();
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bit ad = 0, dd = 0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(ad && dd)) begin
      @(negedge aclk);
      ad |= awr;
      dd |= wr_rdy;
      @(posedge aclk);
      if (ad) awv <= 1'b0;
      if (dd) wv <= 1'b0;
    end
    do @(negedge aclk); while (!bv);
    rs = bresp;
    @(posedge aclk);
  endtask
  task automatic rdr(input logic [3:0] a);
    ara <= a;
    arv <= 1'b1;
    do @(negedge aclk); while (!arr);
    @(posedge aclk);
    arv <= 1'b0;
    do @(negedge aclk); while (!rv);
    rd = rdata;
    rs = rresp;
    @(posedge aclk);
  endtask
  task automatic gap();
    n = 0;
    do begin @(negedge aclk); n++; end while (!tick);
  endtask
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(`ADDR_SCAN_MASK);
    chk("mask reset", rd, 32'h0);
    wr(`ADDR_SCAN_MASK, 32'h0000_FFFF);
    chk("bresp", {30'h0, rs}, 32'h0);
    rdr(`ADDR_SCAN_MASK);
    chk("mask", rd, 32'h0000_9FFF);
    chk("enable", {16'h0, en}, 32'h0000_9FFF);
    wr(`ADDR_SCAN_MASK, 32'h0000_1FFF);
    rdr(`ADDR_SCAN_MASK);
    chk("mask low", rd, 32'h0000_1FFF);
    chk("enable off", {16'h0, en}, 32'h0000_1FFF);
    rdr(4'h1);
    chk("unmapped", {rd[29:0], rs}, {30'h0, `RESP_SLVERR});
    for (int d = 0; d < 4; d += 3) begin
      wr(`ADDR_CLK_CTRL, d);
      gap();
      gap();
      gap();
      chk("tick period", n, 2 * (d + 1));
    end
    wr(`ADDR_CLK_CTRL, 32'h0);
    wr(`ADDR_SCAN_MASK, 32'h0000_8005);
    ch = chan;
    wr(`ADDR_SCAN_CTRL, 32'h1);
    repeat (40) begin
      @(negedge aclk);
      if (chan !== ch) sq.push_back(chan);
      ch = chan;
    end
    @(posedge aclk);
    chk("scan order", {sq[0], sq[1], sq[2], sq[3], sq[4]}, 32'h0002_F02);
    rdr(`ADDR_SCAN_STATUS);
    chk("active", rd[4], 32'h1);
    chk("active pin", act, 32'h1);
    wr(`ADDR_SCAN_CTRL, 32'h0);
    rdr(`ADDR_SCAN_STATUS);
    chk("idle status", rd, 32'h0000_000F);
    chk("idle pin", act, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
